// ==== src/istb_pkg.sv ====
// constants, register map and types for the interrupt sources and time base block
package istb_pkg;
	localparam logic [3:0] ADDR_PSC0   = 4'h0;
	localparam logic [3:0] ADDR_PSC1   = 4'h1;
	localparam logic [3:0] ADDR_TIMEBASE0_CONTROL   = 4'h2;
	localparam logic [3:0] ADDR_TIMEBASE1_CONTROL   = 4'h3;
	localparam logic [3:0] ADDR_INTC0  = 4'h4;
	localparam logic [3:0] ADDR_INTC1  = 4'h5;
	localparam logic [3:0] ADDR_EXT_EDGE_SELECT  = 4'h6;
	localparam logic [3:0] ADDR_STAT   = 4'h7;
	// intc0 enables, intc1 flags: bit order follows source index
	localparam int SRC_N = 7;
	localparam int SRC_EXTA = 0;
	localparam int SRC_EXTB = 1;
	localparam int SRC_TOUCH = 2;
	localparam int SRC_SERIAL = 3;
	localparam int SRC_CONV = 4;
	localparam int SRC_TB0 = 5;
	localparam int SRC_TB1 = 6;
	localparam int GIE_BIT = 7;
	localparam int TB_RUN_BIT = 7;
	localparam int TB_CNT_W = 15;
	localparam int TB_BASE_POW = 8;
	localparam int TB_PER_MSB = 2;
	localparam int PSC_MSB = 1;
	localparam int EDGE_MSB = 3;
	localparam int EDGE_SEL_W = 2;
	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [1:0] SRC_SYS   = 2'h0;
	localparam logic [1:0] SRC_SYS4  = 2'h1;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] VEC_NONE = 3'h7;
	typedef enum logic [2:0] {
		ISTB_IDLE  = 3'b001,
		ISTB_REQ   = 3'b010,
		ISTB_ACK   = 3'b100
	} istb_state_type;
endpackage : istb_pkg

// ==== src/istb_top.sv ====
// independent interrupt sources with two time base generators
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1: external pin flag sets on the selected edge type.
// R2: external vector only with global, pin enable, stack not full, flag.
// R3: servicing external interrupt clears its flag and global enable.
// R4: edge select offers off, rising, falling, both.
// R5: pin acts as interrupt only if enabled, selected and input.
// R6: pull-high selection stays in force in interrupt use.
// R7: touch flag sets on manual overflow or all auto scans done.
// R8: touch flag vectors when enabled; service clears flag and global.
// R9: serial request from any of six unit conditions.
// R10: serial service clears serial flag and global, not unit status.
// R11: conversion done flag; vectors when enabled; service clears both.
// R12: each time base sets its flag on divider overflow.
// R13: time base flag vectors when enabled; service clears flag, global.
// R14: prescaler 0 source: 00 system, 01 system/4, 1x subsystem.
// R15: prescaler 1 same encoding, clocks time base 1.
// R16: time base 0 runs on bit 7, overflow after 2^(8+period).
// R17: time base 1 runs on bit 7, same period encoding.
// R18: prescaler select bits 7 to 2 read zero.
// R19: global enable low blocks vectoring; flags still set and held.
// R20: stack full blocks acknowledgement.
// R21: any flag rising wakes device regardless of enables; external pin edges set a flag and wake only with their irq_enable bit set.
// R22: fixed priority grants the lowest-index pending source.
// R23: divider held at zero while its run bit is clear.
module istb_top (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic [1:0] ext_irq_pin,
	input  wire logic [1:0] ext_pin_func_sel,
	input  wire logic [1:0] ext_pin_dir_in,
	input  wire logic [1:0] ext_pull_high_sel,
	output logic      [1:0] ext_pull_high_en,
	input  wire logic       touch_slot_overflow,
	input  wire logic       touch_manual_mode,
	input  wire logic       touch_auto_scan_done,
	input  wire logic [5:0] serial_events,
	input  wire logic       conv_finished,
	input  wire logic       subsystem_tick,
	input  wire logic       stack_full,
	output logic            irq_request,
	output logic      [2:0] irq_vector,
	input  wire logic       irq_service,
	output logic            wake_up
);
	localparam logic [3:0] ADDR_PSC0 = istb_pkg::ADDR_PSC0;
	localparam int SRC_N = istb_pkg::SRC_N;
	localparam int TB_CNT_W = istb_pkg::TB_CNT_W;
	typedef istb_pkg::istb_state_type istb_state_type;

	logic [SRC_N-1:0] irq_enable;
	logic [SRC_N-1:0] irq_flag;
	logic             global_irq_enable;
	logic [3:0]       ext_edge_select;
	logic [1:0]       prescaler0_src;
	logic [1:0]       prescaler1_src;
	logic             timebase0_run;
	logic             timebase1_run;
	logic [2:0]       timebase0_period;
	logic [2:0]       timebase1_period;
	logic [1:0]       ext_pin_q;
	logic [1:0]       div4_cnt;
	logic [TB_CNT_W-1:0] tb0_cnt;
	logic [TB_CNT_W-1:0] tb1_cnt;
	logic             serial_ev_any_q;
	istb_state_type   state;
	logic [SRC_N-1:0] set_ev;
	logic [SRC_N-1:0] svc_clr;
	logic [SRC_N-1:0] pend;
	logic [2:0]       next_vector;
	logic             grant_ok;
	logic             tick0;
	logic             tick1;
	logic             tb0_ovf;
	logic             tb1_ovf;
	logic [1:0]       ext_active;
	logic [1:0]       ext_edge;
	logic             serial_ev_any;
	logic             svc_now;

	// prescaler tick from source select
	function automatic logic psc_tick(input logic [1:0] sel, input logic d4, input logic sub);
		if (sel == istb_pkg::SRC_SYS)
			psc_tick = 1'b1;
		else if (sel == istb_pkg::SRC_SYS4)
			psc_tick = d4;
		else
			psc_tick = sub;
	endfunction : psc_tick

	// overflow when low (8+period) bits all ones
	function automatic logic tb_overflow(input logic [TB_CNT_W-1:0] cnt, input logic [2:0] per);
		logic [TB_CNT_W-1:0] mask;
		mask = TB_CNT_W'((32'h1 << (32'(istb_pkg::TB_BASE_POW) + 32'(per))) - 32'h1);
		tb_overflow = (cnt & mask) == mask;
	endfunction : tb_overflow

	function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
		unique case (sel)
			istb_pkg::EDGE_OFF:  edge_hit = 1'b0;
			istb_pkg::EDGE_RISE: edge_hit = ~prev & cur;
			istb_pkg::EDGE_FALL: edge_hit = prev & ~cur;
			istb_pkg::EDGE_BOTH: edge_hit = prev ^ cur;
		endcase
	endfunction : edge_hit

	// control byte readback: run bit and period, unused bits zero
	function automatic logic [7:0] ctl_byte(input logic run, input logic [2:0] per);
		ctl_byte = istb_pkg::RESET_BYTE;
		ctl_byte[istb_pkg::TB_RUN_BIT] = run;
		ctl_byte[istb_pkg::TB_PER_MSB:0] = per;
	endfunction : ctl_byte

	function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
		input logic [3:0] target);
		reg_hit = strobe && (addr == target);
	endfunction : reg_hit

	assign tick0 = psc_tick(prescaler0_src, div4_cnt == istb_pkg::DIV4_LAST,
		subsystem_tick); // R14
	assign tick1 = psc_tick(prescaler1_src, div4_cnt == istb_pkg::DIV4_LAST,
		subsystem_tick); // R15
	assign tb0_ovf = timebase0_run & tick0 & tb_overflow(tb0_cnt, timebase0_period); // R16
	assign tb1_ovf = timebase1_run & tick1 & tb_overflow(tb1_cnt, timebase1_period); // R17
	assign serial_ev_any = |serial_events;

	always_comb begin
		for (int i = 0; i < $bits(ext_irq_pin); i++) begin
			ext_active[i] = irq_enable[i] & ext_pin_func_sel[i] & ext_pin_dir_in[i]; // R5
			ext_edge[i] = ext_active[i] & edge_hit(
				ext_edge_select[istb_pkg::EDGE_SEL_W*i +: istb_pkg::EDGE_SEL_W],
				ext_pin_q[i], ext_irq_pin[i]); // R1 R4
		end
		set_ev = '0;
		set_ev[istb_pkg::SRC_EXTA] = ext_edge[0];
		set_ev[istb_pkg::SRC_EXTB] = ext_edge[1];
		set_ev[istb_pkg::SRC_TOUCH] = (touch_slot_overflow & touch_manual_mode)
			| touch_auto_scan_done; // R7
		set_ev[istb_pkg::SRC_SERIAL] = serial_ev_any & ~serial_ev_any_q; // R9
		set_ev[istb_pkg::SRC_CONV] = conv_finished; // R11
		set_ev[istb_pkg::SRC_TB0] = tb0_ovf; // R12
		set_ev[istb_pkg::SRC_TB1] = tb1_ovf; // R12
	end

	assign pend = irq_flag & irq_enable;
	assign grant_ok = global_irq_enable & ~stack_full; // R2 R8 R13 R19 R20

	always_comb begin
		next_vector = istb_pkg::VEC_NONE;
		for (int j = SRC_N - 1; j >= 0; j--) begin
			if (pend[j])
				next_vector = 3'(j); // R22
		end
	end

	assign svc_now = (state == istb_pkg::ISTB_REQ) && irq_service;

	// flag cleared by service of the granted source only
	always_comb begin
		svc_clr = '0;
		if (svc_now)
			svc_clr[irq_vector] = 1'b1; // R3 R8 R10 R11 R13
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ext_pin_q <= '0;
		end else begin
			ext_pin_q <= ext_irq_pin;
		end
	end

	// serial unit levels stay high; only their first rise counts
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			serial_ev_any_q <= 1'b0;
		end else begin
			serial_ev_any_q <= serial_ev_any;
		end
	end

	// free-running quarter-rate divider shared by both prescalers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			div4_cnt <= '0;
		end else begin
			div4_cnt <= div4_cnt + 2'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tb0_cnt <= '0;
		end else begin
			if (!timebase0_run)
				tb0_cnt <= '0; // R23
			else if (tick0)
				tb0_cnt <= tb0_ovf ? '0 : tb0_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tb1_cnt <= '0;
		end else begin
			if (!timebase1_run)
				tb1_cnt <= '0; // R23
			else if (tick1)
				tb1_cnt <= tb1_ovf ? '0 : tb1_cnt + 1'b1;
		end
	end

	// set beats both hardware and software clear
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_flag <= '0;
		end else begin
			if (reg_hit(reg_wr, reg_addr, istb_pkg::ADDR_INTC1))
				irq_flag <= (reg_wdata[SRC_N-1:0] & ~svc_clr) | set_ev; // R19
			else
				irq_flag <= (irq_flag & ~svc_clr) | set_ev; // R19
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_enable <= '0;
			ext_edge_select <= '0;
		end else if (reg_hit(reg_wr, reg_addr, istb_pkg::ADDR_INTC0)) begin
			irq_enable <= reg_wdata[SRC_N-1:0];
		end else if (reg_hit(reg_wr, reg_addr, istb_pkg::ADDR_EXT_EDGE_SELECT)) begin
			ext_edge_select <= reg_wdata[istb_pkg::EDGE_MSB:0]; // R4
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prescaler0_src <= '0;
			prescaler1_src <= '0;
		end else if (reg_hit(reg_wr, reg_addr, ADDR_PSC0)) begin
			prescaler0_src <= reg_wdata[istb_pkg::PSC_MSB:0]; // R14
		end else if (reg_hit(reg_wr, reg_addr, istb_pkg::ADDR_PSC1)) begin
			prescaler1_src <= reg_wdata[istb_pkg::PSC_MSB:0]; // R15
		end
	end

	// period may change while running; the new mask applies at once
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			timebase0_run <= 1'b0;
			timebase0_period <= '0;
		end else if (reg_hit(reg_wr, reg_addr, istb_pkg::ADDR_TIMEBASE0_CONTROL)) begin
			timebase0_run <= reg_wdata[istb_pkg::TB_RUN_BIT]; // R16
			timebase0_period <= reg_wdata[istb_pkg::TB_PER_MSB:0];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			timebase1_run <= 1'b0;
			timebase1_period <= '0;
		end else if (reg_hit(reg_wr, reg_addr, istb_pkg::ADDR_TIMEBASE1_CONTROL)) begin
			timebase1_run <= reg_wdata[istb_pkg::TB_RUN_BIT]; // R17
			timebase1_period <= reg_wdata[istb_pkg::TB_PER_MSB:0];
		end
	end

	// service clear overrides a same-cycle software write
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			global_irq_enable <= 1'b0;
		end else if (svc_now) begin
			global_irq_enable <= 1'b0; // R3 R8 R10 R11 R13
		end else if (reg_hit(reg_wr, reg_addr, istb_pkg::ADDR_INTC0)) begin
			global_irq_enable <= reg_wdata[istb_pkg::GIE_BIT];
		end
	end

	// request held until core services it or grant_ok drops; vector frozen while requesting
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= istb_pkg::ISTB_IDLE;
			irq_request <= 1'b0;
			irq_vector <= istb_pkg::VEC_NONE;
		end else begin
			unique case (state)
				istb_pkg::ISTB_IDLE: begin
					if (grant_ok && next_vector != istb_pkg::VEC_NONE) begin
						state <= istb_pkg::ISTB_REQ; // R2
						irq_request <= 1'b1;
						irq_vector <= next_vector;
					end
				end
				istb_pkg::ISTB_REQ: begin
					if (irq_service) begin
						state <= istb_pkg::ISTB_ACK;
						irq_request <= 1'b0;
					end else if (!grant_ok) begin
						// withdrawn request retires through the same vector hold
						state <= istb_pkg::ISTB_ACK; // R19 R20
						irq_request <= 1'b0;
					end
				end
				istb_pkg::ISTB_ACK: begin
					state <= istb_pkg::ISTB_IDLE;
					irq_vector <= istb_pkg::VEC_NONE;
				end
				default: state <= istb_pkg::ISTB_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wake_up <= 1'b0;
		end else begin
			wake_up <= |(set_ev & ~irq_flag); // R21
		end
	end

	// pull-high passes through untouched by interrupt use of the pin
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ext_pull_high_en <= '0;
		end else begin
			ext_pull_high_en <= ext_pull_high_sel; // R6
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= istb_pkg::RESET_BYTE;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_PSC0: reg_rdata <= 8'(prescaler0_src); // R18
				istb_pkg::ADDR_PSC1: reg_rdata <= 8'(prescaler1_src); // R18
				istb_pkg::ADDR_TIMEBASE0_CONTROL: reg_rdata <= ctl_byte(timebase0_run, timebase0_period);
				istb_pkg::ADDR_TIMEBASE1_CONTROL: reg_rdata <= ctl_byte(timebase1_run, timebase1_period);
				istb_pkg::ADDR_INTC0: reg_rdata <= {global_irq_enable, irq_enable};
				istb_pkg::ADDR_INTC1: reg_rdata <= 8'(irq_flag);
				istb_pkg::ADDR_EXT_EDGE_SELECT: reg_rdata <= 8'(ext_edge_select);
				istb_pkg::ADDR_STAT: reg_rdata <= 8'(state);
				default: reg_rdata <= istb_pkg::RESET_BYTE;
			endcase
		end else begin
			reg_rdata <= istb_pkg::RESET_BYTE;
		end
	end
endmodule : istb_top
`default_nettype wire

// ==== test/istb_asserts.sv ====
// port assertions for the interrupt sources and time base block
`timescale 1ns/1ns
`default_nettype none
module istb_asserts (
	input wire logic       clk_sys,
	input wire logic       arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] ext_pull_high_sel,
	input wire logic [1:0] ext_pull_high_en,
	input wire logic       stack_full,
	input wire logic       irq_request,
	input wire logic [2:0] irq_vector,
	input wire logic       irq_service
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	chk_psc_upper_zero: assert property (reg_rd && reg_addr == istb_pkg::ADDR_PSC0
		|=> reg_rdata[7:2] == 6'h00) else $error("prescaler upper bits not zero");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	chk_stack_block: assert property (stack_full |=> !irq_request)
		else $error("request while stack full");
	chk_req_gate: assert property ($rose(irq_request) |-> !$past(stack_full))
		else $error("request raised from full stack");
	chk_service_drop: assert property (irq_service && irq_request |=> !irq_request)
		else $error("request kept after service");
	chk_vector_valid: assert property (irq_request |-> irq_vector != istb_pkg::VEC_NONE)
		else $error("request without source");
	chk_vector_none: assert property ($fell(irq_request) |=> irq_vector == istb_pkg::VEC_NONE)
		else $error("vector kept after request");
	chk_pull_kept: assert property ($past(arst_n) |-> ext_pull_high_en == $past(ext_pull_high_sel))
		else $error("pull-high selection lost");
endmodule : istb_asserts
bind istb_top istb_asserts i_istb_asserts (.clk_sys, .arst_n, .reg_addr, .reg_rd, .reg_rdata,
	.ext_pull_high_sel, .ext_pull_high_en, .stack_full, .irq_request, .irq_vector, .irq_service);
`default_nettype wire

// ==== test/istb_core_model.sv ====
// core sequencer model that takes a request after a short latency
`timescale 1ns/1ns
`default_nettype none
module istb_core_model #(parameter int LAT = 2) (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic       irq_request,
	input  wire logic [2:0] irq_vector,
	output logic            irq_service,
	output logic      [2:0] taken_vec
);
	int wait_cnt;
	// a withdrawn request restarts the wait, as the core never vectors late
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_service <= 1'b0;
			taken_vec   <= istb_pkg::VEC_NONE;
			wait_cnt    <= 0;
		end else begin
			irq_service <= 1'b0;
			wait_cnt    <= (irq_request && !irq_service) ? wait_cnt + 1 : 0;
			if (irq_request && !irq_service && wait_cnt == LAT) begin
				irq_service <= 1'b1;
				taken_vec   <= irq_vector;
			end
		end
	end
endmodule : istb_core_model
`default_nettype wire

// ==== test/istb_top_bench.sv ====
// self-checking bench for the interrupt sources and time base block
`timescale 1ns/1ns
`default_nettype none
module istb_top_bench;
	logic       clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [1:0] ext_irq_pin = 2'h0, ext_pin_func_sel = 2'h3, ext_pin_dir_in = 2'h3;
	logic [1:0] ext_pull_high_sel = 2'h0, ext_pull_high_en;
	logic       touch_slot_overflow = 1'b0, touch_manual_mode = 1'b0;
	logic       touch_auto_scan_done = 1'b0, conv_finished = 1'b0;
	logic [5:0] serial_events = 6'h00;
	logic       subsystem_tick = 1'b0, stack_full = 1'b0;
	logic       irq_request, irq_service, wake_up;
	logic [2:0] irq_vector, taken_vec;
	int         err_total = 0, total_checks = 0, cycles = 0, wakes = 0;
	logic [19:0] reg_rows [11] = '{20'h0FF03, 20'h1FE02, 20'h2FF87, 20'h37A02, 20'h6FF0F,
		20'h9FF00, 20'h00000, 20'h10000, 20'h20000, 20'h30000, 20'h60000};
	logic [19:0] evt_rows [10] = '{20'h00108, 20'h00208, 20'h00408, 20'h00808, 20'h01008,
		20'h02008, 20'h04010, 20'h08000, 20'h18004, 20'h20004};
	logic [2:0] vec_tab [3] = '{3'h0, 3'h3, 3'h4};
	logic [7:0] flag_tab [3] = '{8'h18, 8'h10, 8'h00};
	istb_top i_istb_top (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.ext_irq_pin, .ext_pin_func_sel, .ext_pin_dir_in, .ext_pull_high_sel, .ext_pull_high_en,
		.touch_slot_overflow, .touch_manual_mode, .touch_auto_scan_done, .serial_events,
		.conv_finished, .subsystem_tick, .stack_full, .irq_request, .irq_vector, .irq_service,
		.wake_up);
	istb_core_model i_istb_core_model (.clk_sys, .arst_n, .irq_request, .irq_vector,
		.irq_service, .taken_vec);
	always #5 clk_sys = ~clk_sys;
	// subsystem ticks every eighth clock; hang guard well above the run length
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		subsystem_tick <= (cycles[2:0] == 3'h7);
		if (wake_up === 1'b1) wakes <= wakes + 1;
		if (cycles > 12000) begin
			err_total++;
			complete_run();
		end
	end
	task complete_run;
		if (err_total == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run
	task chk(input logic ok);
		total_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED %0t unexpected value", $time);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		// idle edge so a following write never reassigns the strobe at once
		@(posedge clk_sys);
	endtask : wr
	// read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk((reg_rdata & m) === e);
		@(posedge clk_sys);
	endtask : rd
	task hit(input logic [19:0] r);
		{touch_auto_scan_done, touch_manual_mode, touch_slot_overflow, conv_finished,
			serial_events} <= r[17:8];
		@(posedge clk_sys);
		{touch_auto_scan_done, touch_manual_mode, touch_slot_overflow, conv_finished,
			serial_events} <= 10'h000;
		cyc(3);
		rd(4'h5, r[7:0], 8'hFF);
		wr(4'h5, 8'h00);
	endtask : hit
	task tbase(input logic [3:0] ap, input logic [7:0] src, ctl, m, input int lo, hi);
		wr(ap, src);
		wr(ap + 4'h2, ctl);
		wr(4'h5, 8'h00);
		cyc(lo);
		rd(4'h5, 8'h00, m);
		cyc(hi);
		rd(4'h5, m, m);
		wr(ap + 4'h2, 8'h00);
	endtask : tbase
	initial begin
		cyc(20);
		chk(irq_vector === istb_pkg::VEC_NONE && irq_request === 1'b0);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 8; i++) rd(4'(i), (i == 7) ? 8'h01 : 8'h00, 8'hFF);
		foreach (reg_rows[i]) begin
			wr(reg_rows[i][19:16], reg_rows[i][15:8]);
			rd(reg_rows[i][19:16], reg_rows[i][7:0], 8'hFF);
		end
		wr(4'h4, 8'h03);
		ext_pull_high_sel <= 2'h3;
		for (int m = 0; m < 4; m++) begin
			wr(4'h6, 8'(m * 5));
			ext_irq_pin <= 2'h3;
			cyc(3);
			rd(4'h5, {6'h00, {2{m[0]}}}, 8'hFF);
			wr(4'h5, 8'h00);
			ext_irq_pin <= 2'h0;
			cyc(3);
			rd(4'h5, {6'h00, {2{m[1]}}}, 8'hFF);
			wr(4'h5, 8'h00);
		end
		{ext_pin_dir_in, ext_pin_func_sel} <= 4'h6;
		ext_irq_pin <= 2'h3;
		cyc(3);
		rd(4'h5, 8'h00, 8'hFF);
		chk(ext_pull_high_en === 2'h3);
		ext_irq_pin <= 2'h0;
		cyc(2);
		{ext_pin_dir_in, ext_pin_func_sel} <= 4'hF;
		foreach (evt_rows[i]) hit(evt_rows[i]);
		chk(wakes > 0);
		wr(4'h4, 8'h1F);
		stack_full <= 1'b1;
		wr(4'h5, 8'h19);
		cyc(3);
		chk(irq_request === 1'b0);
		wr(4'h4, 8'h9F);
		cyc(4);
		chk(irq_request === 1'b0);
		stack_full <= 1'b0;
		for (int j = 0; j < 3; j++) begin
			cyc(8);
			chk(taken_vec === vec_tab[j]);
			rd(4'h5, flag_tab[j], 8'hFF);
			rd(4'h4, 8'h1F, 8'hFF);
			wr(4'h4, 8'h9F);
		end
		wr(4'h4, 8'h00);
		tbase(4'h0, 8'h00, 8'h81, 8'h20, 500, 20);
		tbase(4'h0, 8'h01, 8'h80, 8'h20, 1000, 40);
		tbase(4'h1, 8'h02, 8'h80, 8'h40, 2000, 100);
		complete_run();
	end
endmodule : istb_top_bench
`default_nettype wire
